/* rgd_top.sv */
// receive guard timer, crc preset selection and receive bit decoder with apb registers
// assumes synchronous inputs on mclk and an apb master that holds each request
// How it works
// - guard reload value at bits 27:8
// - zero reload skips the guard interval
// - prescaler reload at bits 7:0 divides clock
// - arbitrary crc preset at bits 31:16
// - parity type: 0 even, 1 odd
// - parity bit stripped from data and checked
// - parity mismatch flags error, reception continues
// - type A detection sets parity enable/type
// - after collision: clear bits or keep them
// - alignment field places the first bit
// - selector picks preset; 5-bit uses low byte
// - code 000 gives preset 0000h, reset choice
// - codes 001 to 101 map to fixed presets, 110 gives 0000h, 111 the arbitrary preset
// - crc type bit: 16-bit or 5-bit
// - inversion bit compares against F0B8h
`default_nettype none
module rgd_top
	import rgd_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic              tx_end,
	input  wire logic              rx_frame_start,
	input  wire rgd_pkg::rgd_rx_bit_t rx_bit_in,
	input  wire logic              auto_detect_en,
	input  wire logic              md_type_a,
	input  wire logic              md_type_b,
	input  wire logic              md_jis,
	output var  logic              rx_guard_active,
	output var  logic [7:0]        rx_byte,
	output var  logic              rx_byte_valid,
	output var  logic              integrity_fault_flag,
	output var  logic [15:0]       crc_preset,
	output var  logic [15:0]       crc_residue,
	output var  logic              crc5_mode
);
	import rgd_pkg::*;

	// register state
	rgd_guard_cfg_t guard_q;         // guard timer config
	rgd_crc_cfg_t   crc_q;           // crc and parity config
	logic [31:0]    prdata_q;        // read data
	logic           pready_q;        // access answer
	logic           pslverr_q;       // unmapped address answer
	// guard timer state
	logic [19:0]    gcnt_q;          // guard count
	logic [7:0]     pcnt_q;          // prescaler count
	logic           gact_q;          // guard running
	// decoder state
	rgd_phase_t     phase_q;         // data or parity phase
	logic [2:0]     bitpos_q;        // next bit slot
	logic [7:0]     acc_q;           // byte being assembled
	logic           col_q;           // collision seen in frame
	logic [7:0]     byte_q;          // last finished byte
	logic           bvalid_q;        // byte strobe
	logic           fault_q;         // integrity fault, sticky per frame
	logic [15:0]    preset_q;        // selected crc preset
	logic [15:0]    residue_q;       // residue to compare against

	// apb decode
	wire            sel_guard   = (paddr == RGD_ADDR_GUARD);
	wire            sel_crc     = (paddr == RGD_ADDR_CRC);
	wire            mapped      = sel_guard | sel_crc;
	wire            access      = psel & penable;
	wire            first_acc   = access & ~pready_q;
	wire            done        = access & pready_q;
	wire            wr_guard    = done & pwrite & sel_guard & ~pslverr_q;
	wire            wr_crc      = done & pwrite & sel_crc & ~pslverr_q;
	// byte strobes expanded to a bit mask
	wire [31:0]     strb_mask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [31:0]     guard_wr_v  = ((guard_q & ~strb_mask) | (pwdata & strb_mask)) & RGD_MASK_GUARD;
	wire [31:0]     crc_wr_v    = ((crc_q & ~strb_mask) | (pwdata & strb_mask)) & RGD_MASK_CRC;
	wire [31:0]     rd_word     = sel_guard ? (guard_q & RGD_MASK_GUARD) :
	                              sel_crc   ? (crc_q & RGD_MASK_CRC) : RGD_RST_WORD;

	// mode detector overrides, only while automatic detection is on
	wire            det_a       = auto_detect_en & md_type_a;
	wire            det_b       = auto_detect_en & md_type_b;
	wire            det_j       = auto_detect_en & md_jis;

	// apb answer: one wait cycle so every output comes from a flop
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= RGD_RST_WORD;
		end else begin
			pready_q  <= first_acc;
			pslverr_q <= first_acc & ~mapped;
			if (first_acc) begin
				prdata_q <= rd_word;
			end
		end
	end

	// guard timer register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			guard_q <= RGD_RST_WORD;
		end else if (wr_guard) begin
			guard_q <= guard_wr_v;
		end
	end

	// crc register; the detector wins over a same-cycle software write
	rgd_crc_cfg_t crc_d;
	always_comb begin
		crc_d = wr_crc ? rgd_crc_cfg_t'(crc_wr_v) : crc_q;
		if (det_a) begin
			crc_d.par_en  = 1'b1;
			crc_d.par_odd = 1'b1;
			crc_d.sel     = RGD_SEL_6363;
			crc_d.crc_inv = 1'b0;
		end else if (det_b) begin
			crc_d.sel     = RGD_SEL_FFFF;
			crc_d.crc_inv = 1'b1;
		end else if (det_j) begin
			crc_d.sel     = RGD_SEL_ZERO;
			crc_d.crc_inv = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			crc_q <= RGD_RST_WORD;
		end else begin
			crc_q <= crc_d;
		end
	end

	// guard timer: runs reload*(presc+1) cycles after a transmission ends
	wire            pre_wrap    = (pcnt_q == 8'h00);
	wire            g_start     = tx_end & (guard_q.reload != 20'h0_0000);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			gact_q <= 1'b0;
			gcnt_q <= 20'h0_0000;
			pcnt_q <= 8'h00;
		end else if (g_start) begin
			gact_q <= 1'b1;
			gcnt_q <= guard_q.reload;
			pcnt_q <= guard_q.presc;
		end else if (gact_q && pre_wrap) begin
			pcnt_q <= guard_q.presc;
			gcnt_q <= gcnt_q - 20'h0_0001;
			gact_q <= (gcnt_q != 20'h0_0001);
		end else if (gact_q) begin
			pcnt_q <= pcnt_q - 8'h01;
		end
	end

	// receiver input is ignored while the guard runs
	wire            bit_ok      = rx_bit_in.valid & ~gact_q;
	wire            frame_go    = rx_frame_start & ~gact_q;
	// bits after a collision are cleared unless kept
	wire            col_now     = col_q | rx_bit_in.collision;
	wire            bit_val     = (col_q & ~crc_q.keep_col) ? 1'b0 : rx_bit_in.value;
	wire [7:0]      acc_new     = acc_q | ({7'h00, bit_val} << bitpos_q);
	wire            byte_full   = (bitpos_q == RGD_LAST_BIT);
	// parity: ones in byte plus parity bit must match the selected type
	wire            par_bad     = ((^acc_q) ^ rx_bit_in.value) != crc_q.par_odd;

	// decoder datapath
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			phase_q  <= RGD_DATA;
			bitpos_q <= 3'h0;
			acc_q    <= 8'h00;
			col_q    <= 1'b0;
			byte_q   <= 8'h00;
			bvalid_q <= 1'b0;
		end else begin
			bvalid_q <= 1'b0;
			if (frame_go) begin
				phase_q  <= RGD_DATA;
				bitpos_q <= crc_q.first_bit_slot;
				acc_q    <= 8'h00;
				col_q    <= 1'b0;
			end else if (bit_ok) begin
				unique case (phase_q)
					RGD_PAR: begin
						// parity bit is checked and dropped from the data
						phase_q  <= RGD_DATA;
						byte_q   <= acc_q;
						bvalid_q <= 1'b1;
						acc_q    <= 8'h00;
					end
					RGD_DATA: begin
						col_q    <= col_now;
						bitpos_q <= bitpos_q + 3'h1;
						if (byte_full && crc_q.par_en) begin
							acc_q   <= acc_new;
							phase_q <= RGD_PAR;
						end else if (byte_full) begin
							byte_q   <= acc_new;
							bvalid_q <= 1'b1;
							acc_q    <= 8'h00;
						end else begin
							acc_q <= acc_new;
						end
					end
				endcase
			end
		end
	end

	// integrity fault: cleared by a new frame, which wins over a mismatch in that cycle
	wire            par_evt     = bit_ok & ~frame_go & (phase_q == RGD_PAR) & par_bad;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fault_q <= 1'b0;
		end else if (par_evt) begin
			fault_q <= 1'b1;
		end else if (frame_go) begin
			fault_q <= 1'b0;
		end
	end

	// preset lookup; reserved code yields zero
	wire [15:0]     preset_full = (crc_q.sel == RGD_SEL_ZERO) ? RGD_PRE_ZERO :
	                              (crc_q.sel == RGD_SEL_6363) ? RGD_PRE_6363 :
	                              (crc_q.sel == RGD_SEL_A671) ? RGD_PRE_A671 :
	                              (crc_q.sel == RGD_SEL_FFFF) ? RGD_PRE_FFFF :
	                              (crc_q.sel == RGD_SEL_0012) ? RGD_PRE_0012 :
	                              (crc_q.sel == RGD_SEL_E012) ? RGD_PRE_E012 :
	                              (crc_q.sel == RGD_SEL_ARB)  ? crc_q.preset :
	                              RGD_PRE_ZERO;
	wire [15:0]     preset_use  = crc_q.crc5 ? {8'h00, preset_full[7:0]} : preset_full;

	// crc settings registered toward the crc engine
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			preset_q  <= RGD_PRE_ZERO;
			residue_q <= RGD_RES_PLAIN;
		end else begin
			preset_q  <= preset_use;
			residue_q <= crc_q.crc_inv ? RGD_RES_INV : RGD_RES_PLAIN;
		end
	end

	// output wiring from flops
	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign rx_guard_active      = gact_q;
	assign rx_byte              = byte_q;
	assign rx_byte_valid        = bvalid_q;
	assign integrity_fault_flag = fault_q;
	assign crc_preset           = preset_q;
	assign crc_residue          = residue_q;
	assign crc5_mode            = crc_q.crc5;

	// checks
	sequence seq_guard_start;
		tx_end && (guard_q.reload != 20'h0_0000);
	endsequence
	sequence seq_read_done;
		psel && penable && pready_q && !pwrite;
	endsequence

	AST_GUARD_LOAD: assert property (@(posedge mclk) disable iff (!rstn)
		seq_guard_start |=> gact_q && (gcnt_q == $past(guard_q.reload)))
		else $error("guard did not load reload value");
	AST_GUARD_OFF: assert property (@(posedge mclk) disable iff (!rstn)
		tx_end && !gact_q && (guard_q.reload == 20'h0_0000) |=> !gact_q)
		else $error("guard ran with zero reload");
	AST_PRESC: assert property (@(posedge mclk) disable iff (!rstn)
		gact_q && pre_wrap && !tx_end |=> (pcnt_q == guard_q.presc) && (gcnt_q == $past(gcnt_q) - 20'h0_0001))
		else $error("prescaler wrap wrong");
	AST_BLOCK: assert property (@(posedge mclk) disable iff (!rstn)
		gact_q && !rx_frame_start |=> $stable(bitpos_q) && !bvalid_q)
		else $error("receiver not held off by guard");
	AST_PARITY: assert property (@(posedge mclk) disable iff (!rstn)
		par_evt |=> fault_q ##1 (fault_q || $past(frame_go)))
		else $error("parity mismatch not flagged");
	AST_DET_A: assert property (@(posedge mclk) disable iff (!rstn)
		det_a |=> crc_q.par_en && crc_q.par_odd ##1 (preset_q == RGD_PRE_6363 || crc_q.crc5))
		else $error("type A detection did not set parity");
	AST_PRESET_ARB: assert property (@(posedge mclk) disable iff (!rstn)
		(crc_q.sel == RGD_SEL_ARB) && !crc_q.crc5 |=> preset_q == $past(crc_q.preset))
		else $error("arbitrary preset not applied");
	AST_PRESET_5: assert property (@(posedge mclk) disable iff (!rstn)
		crc_q.crc5 |=> preset_q[15:8] == 8'h00)
		else $error("5-bit preset high byte not zero");
	AST_RSV: assert property (@(posedge mclk) disable iff (!rstn)
		seq_read_done |-> (sel_guard ? prdata_q[31:28] : prdata_q[15:12]) == 4'h0)
		else $error("reserved bits read nonzero");
	AST_RESIDUE: assert property (@(posedge mclk) disable iff (!rstn)
		det_b |=> crc_q.crc_inv ##1 (residue_q == RGD_RES_INV))
		else $error("inverted residue not selected");
endmodule
`default_nettype wire

/* rgd_pkg.sv */
// package for the receive guard timer and receive decoder configuration block
// assumes a 32-bit apb master and a 25 MHz system clock
`default_nettype none
package rgd_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0]  RGD_IDX_GUARD   = 8'h11;
	localparam logic [7:0]  RGD_IDX_CRC     = 8'h12;
	localparam logic [31:0] RGD_ADDR_GUARD  = {22'h0, RGD_IDX_GUARD, 2'b00};
	localparam logic [31:0] RGD_ADDR_CRC    = {22'h0, RGD_IDX_CRC, 2'b00};
	// writable bit masks; reserved bits read zero
	localparam logic [31:0] RGD_MASK_GUARD  = 32'h0FFF_FFFF;
	localparam logic [31:0] RGD_MASK_CRC    = 32'hFFFF_0FFE;
	localparam logic [31:0] RGD_RST_WORD    = 32'h0000_0000;
	// crc preset selector codes
	localparam logic [2:0]  RGD_SEL_ZERO    = 3'h0;
	localparam logic [2:0]  RGD_SEL_6363    = 3'h1;
	localparam logic [2:0]  RGD_SEL_A671    = 3'h2;
	localparam logic [2:0]  RGD_SEL_FFFF    = 3'h3;
	localparam logic [2:0]  RGD_SEL_0012    = 3'h4;
	localparam logic [2:0]  RGD_SEL_E012    = 3'h5;
	localparam logic [2:0]  RGD_SEL_RSV     = 3'h6;
	localparam logic [2:0]  RGD_SEL_ARB     = 3'h7;
	// crc preset and residue values
	localparam logic [15:0] RGD_PRE_ZERO    = 16'h0000;
	localparam logic [15:0] RGD_PRE_6363    = 16'h6363;
	localparam logic [15:0] RGD_PRE_A671    = 16'hA671;
	localparam logic [15:0] RGD_PRE_FFFF    = 16'hFFFF;
	localparam logic [15:0] RGD_PRE_0012    = 16'h0012;
	localparam logic [15:0] RGD_PRE_E012    = 16'hE012;
	localparam logic [15:0] RGD_RES_PLAIN   = 16'h0000;
	localparam logic [15:0] RGD_RES_INV     = 16'hF0B8;
	localparam logic [2:0]  RGD_LAST_BIT    = 3'h7;
	// guard timer register layout
	typedef struct packed {
		logic [3:0]  rsv;        // reserved, reads zero
		logic [19:0] reload;     // guard reload value
		logic [7:0]  presc;      // prescaler reload
	} rgd_guard_cfg_t;
	// crc and parity register layout
	typedef struct packed {
		logic [15:0] preset;     // arbitrary crc preset
		logic [3:0]  rsv;        // reserved, reads zero
		logic        par_odd;    // parity type
		logic        par_en;     // parity check enable
		logic        keep_col;   // keep bits after collision
		logic [2:0]  first_bit_slot; // first bit position
		logic [2:0]  sel;        // crc preset selector
		logic        crc_inv;    // inverted residue compare
		logic        crc5;       // 5-bit crc mode
		logic        rsv0;       // reserved, reads zero
	} rgd_crc_cfg_t;
	// received bit from the demodulator
	typedef struct packed {
		logic valid;             // bit strobe
		logic value;             // bit value
		logic collision;         // collision seen on this bit
	} rgd_rx_bit_t;
	// decoder phase
	typedef enum logic {
		RGD_DATA = 1'b0,
		RGD_PAR  = 1'b1
	} rgd_phase_t;
endpackage
`default_nettype wire

/* rgd_rx_model.sv */
// far-side model: remote target through the receive chain, frame start and bit strobes
// assumes the bench calls send_frame from its main sequence on the mclk domain
`default_nettype none
module rgd_rx_model (
	input  wire logic                 mclk,
	output var  logic                 frame_start,
	output var  rgd_pkg::rgd_rx_bit_t rx_bit
);
	import rgd_pkg::*;
	// quiet line until the first frame
	initial begin
		frame_start = 1'b0;
		rx_bit      = '0;
	end
	// one start pulse, then n bits back to back, lsb first; the line carries the raw
	// bits, so only the receiver decides what survives after a collision
	task automatic send_frame(input logic [17:0] bits, input int n, input int col);
		@(posedge mclk) frame_start <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge mclk) frame_start <= 1'b0;
			rx_bit <= '{valid: 1'b1, value: bits[i], collision: (i == col)};
		end
		// released line: value flipped so a stale level never passes for data
		@(posedge mclk) rx_bit <= '{valid: 1'b0, value: ~bits[n-1], collision: 1'b0};
		frame_start <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* rx_guard_and_decode_config_test.sv */
// self-checking bench: apb registers, guard timer, preset selection, receive decoder
// assumes rgd_top and rgd_rx_model; a single 25 MHz mclk
`default_nettype none
module rx_guard_and_decode_config_test;
	timeunit 1ns;
	timeprecision 1ns;
	import rgd_pkg::*;
	logic        mclk, rstn, psel, penable, pwrite, tx_end, frame_start;    // bench-driven controls
	logic        auto_detect_en, md_type_a, md_type_b, md_jis;             // detector pulses
	logic [31:0] paddr, pwdata, prdata, rd;                                 // apb data
	logic [3:0]  pstrb;                                                     // apb byte lanes
	logic        pready, pslverr, err, rx_guard_active, rx_byte_valid;     // design status
	logic        integrity_fault_flag, crc5_mode;                          // decoder status
	logic [7:0]  rx_byte, got_q;                                            // last byte seen
	logic [15:0] crc_preset, crc_residue;                                   // crc outputs
	rgd_rx_bit_t rx_bit;                                                    // bit strobe from model
	int          mismatches, total_checks, gcnt, nbytes, nb;                // bookkeeping
	logic [15:0] pre_tab [8] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF,
		16'h0012, 16'hE012, 16'h0000, 16'h1234};                            // presets per selector
	// 40 ns clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	rgd_top rgd_top_inst (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_end(tx_end), .rx_frame_start(frame_start), .rx_bit_in(rx_bit), .auto_detect_en(auto_detect_en),
		.md_type_a(md_type_a), .md_type_b(md_type_b), .md_jis(md_jis), .rx_guard_active(rx_guard_active),
		.rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .integrity_fault_flag(integrity_fault_flag),
		.crc_preset(crc_preset), .crc_residue(crc_residue), .crc5_mode(crc5_mode));
	rgd_rx_model rgd_rx_model_inst (.mclk(mclk), .frame_start(frame_start), .rx_bit(rx_bit));
	// capture byte pulses and guard-active cycles; the pulse lasts one cycle only
	always @(posedge mclk) begin
		if (rx_byte_valid === 1'b1) begin
			got_q  <= rx_byte;
			nbytes <= nbytes + 1;
		end
		if (rx_guard_active === 1'b1)
			gcnt <= gcnt + 1;
	end
	// closing report, reached from the end of the run or a timeout
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// shared compare
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
		int n;
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= addr;
		pwdata <= data;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// configure decoder, send one frame, compare last byte and fault flag
	task automatic frame(input logic [31:0] cfg, input logic [17:0] bits, input int n, input int col,
		input logic [7:0] eb, input logic ef);
		apb(1'b1, RGD_ADDR_CRC, cfg);
		rgd_rx_model_inst.send_frame(bits, n, col);
		repeat (3) @(posedge mclk);
		check(got_q, eb);
		check(integrity_fault_flag, ef);
	endtask
	// one end-of-transmission pulse
	task automatic tx_pulse;
		@(posedge mclk) tx_end <= 1'b1;
		@(posedge mclk) tx_end <= 1'b0;
	endtask
	// main sequence
	initial begin
		{rstn, psel, penable, pwrite, tx_end, auto_detect_en, md_type_a, md_type_b, md_jis} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		{mismatches, total_checks, gcnt, nbytes} = '0;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		apb(1'b0, RGD_ADDR_GUARD, 32'h0);
		check(rd, 32'h0000_0000);
		apb(1'b0, RGD_ADDR_CRC, 32'h0);
		check(rd, 32'h0000_0000);
		apb(1'b1, RGD_ADDR_GUARD, 32'hFFFF_FFFF);
		apb(1'b0, RGD_ADDR_GUARD, 32'h0);
		check(rd, 32'h0FFF_FFFF);
		apb(1'b1, RGD_ADDR_CRC, 32'hFFFF_FFFF);
		apb(1'b0, RGD_ADDR_CRC, 32'h0);
		check(rd, 32'hFFFF_0FFE);
		// unmapped place: error, no data, no side effect
		apb(1'b1, 32'h0000_0040, 32'h0);
		check(err, 1'b1);
		apb(1'b0, 32'h0000_004C, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0000_0000);
		apb(1'b0, RGD_ADDR_GUARD, 32'h0);
		check(err, 1'b0);
		check(rd, 32'h0FFF_FFFF);
		// one byte lane written, the other lanes keep their value
		pstrb <= 4'h1;
		apb(1'b1, RGD_ADDR_GUARD, 32'h1234_5611);
		pstrb <= 4'hF;
		apb(1'b0, RGD_ADDR_GUARD, 32'h0);
		check(rd, 32'h0FFF_FF11);
		// every selector code, inversion toggled along
		for (int s = 0; s < 8; s++) begin
			apb(1'b1, RGD_ADDR_CRC, {16'h1234, 10'h000, s[2:0], s[0], 2'b00});
			repeat (2) @(posedge mclk);
			check(crc_preset, pre_tab[s]);
			check(crc_residue, s[0] ? 16'hF0B8 : 16'h0000);
		end
		// 5-bit mode with the arbitrary preset: only its low byte survives
		apb(1'b1, RGD_ADDR_CRC, 32'h1234_003A);
		repeat (2) @(posedge mclk);
		check(crc5_mode, 1'b1);
		check(crc_preset, 32'h0000_0034);
		// guard: reload 2, prescaler 0x7F, a frame inside the guard is dropped
		apb(1'b1, RGD_ADDR_GUARD, 32'h0000_027F);
		gcnt = 0;
		nb = nbytes;
		tx_pulse();
		rgd_rx_model_inst.send_frame(18'h000A5, 8, -1);
		repeat (300) @(posedge mclk);
		check(gcnt, 256);
		check(nbytes, nb);
		// zero reload: no guard at all
		apb(1'b1, RGD_ADDR_GUARD, 32'h0000_007F);
		gcnt = 0;
		tx_pulse();
		repeat (20) @(posedge mclk);
		check(gcnt, 0);
		// decoder frames
		frame(32'h0, 18'h000A5, 8, -1, 8'hA5, 1'b0);
		frame(32'h0C0, 18'h00015, 5, -1, 8'hA8, 1'b0);
		frame(32'h400, 18'h000A5, 9, -1, 8'hA5, 1'b0);
		frame(32'h400, 18'h079A5, 18, -1, 8'h3C, 1'b1);
		frame(32'hC00, 18'h001A5, 9, -1, 8'hA5, 1'b0);
		frame(32'h0, 18'h000FF, 8, 2, 8'h07, 1'b0);
		frame(32'h200, 18'h000FF, 8, 2, 8'hFF, 1'b0);
		// mode detector: type a, type b, jis in turn
		apb(1'b1, RGD_ADDR_CRC, 32'h0);
		// detection off: a type b pulse must leave the settings alone
		@(posedge mclk) md_type_b <= 1'b1;
		@(posedge mclk) md_type_b <= 1'b0;
		repeat (2) @(posedge mclk);
		check(crc_residue, 16'h0000);
		check(crc_preset, 16'h0000);
		auto_detect_en <= 1'b1;
		for (int m = 0; m < 3; m++) begin
			@(posedge mclk) {md_type_a, md_type_b, md_jis} <= 3'b100 >> m;
			@(posedge mclk) {md_type_a, md_type_b, md_jis} <= 3'b000;
			repeat (2) @(posedge mclk);
			check(crc_preset, m == 0 ? 16'h6363 : m == 1 ? 16'hFFFF : 16'h0000);
			check(crc_residue, m == 1 ? 16'hF0B8 : 16'h0000);
			apb(1'b0, RGD_ADDR_CRC, 32'h0);
			if (m == 0)
				check(rd[11:10], 2'b11);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
